// ---- rtl/fos_cfg.svh ----
// Purpose: Constants of the fft overlap sequencer
// Assumes: 32-bit instruction words, 40 MHz clock
// Notes: Byte addresses on the register port
`ifndef FOS_CFG_SVH
`define FOS_CFG_SVH
`define FOS_RAM_WORDS 128
`define FOS_HALF_WORDS 8'h40
`define FOS_OP_HI 31
`define FOS_OP_LO 28
`define FOS_OP_BRING 4'h1
`define FOS_OP_WOUT 4'h2
`define FOS_OP_XFORM 4'h3
`define FOS_OP_JUMP 4'h4
`define FOS_OP_BOTH 2'h2
`define FOS_F_HALF 27
`define FOS_F_REV 26
`define FOS_LEN_HI 24
`define FOS_LEN_LO 17
`define FOS_SUB_HI 16
`define FOS_SUB_LO 14
`define FOS_FPG_HI 13
`define FOS_FPG_LO 11
`define FOS_LPG_HI 10
`define FOS_LPG_LO 8
`define FOS_COEF_HI 7
`define FOS_COEF_LO 0
`define FOS_EXT_HI 15
`define FOS_EXT_LO 0
`define FOS_REG_CTRL 4'h0
`define FOS_REG_START 4'h4
`define FOS_REG_STATUS 4'h8
`define FOS_CTRL_RUN 0
`define FOS_STAT_PC_LO 16
`endif

// ---- rtl/fos_pkg.sv ----
// Purpose: Types shared by the sequencer modules
// Assumes: Nothing
// Notes: Complex words are packed {re, im}
package fos_pkg;
  typedef enum logic [1:0] {
    F_IDLE  = 2'b00,
    F_FETCH = 2'b01,
    F_ISSUE = 2'b10,
    F_JUMP  = 2'b11
  } fos_fetch_t;
  typedef enum logic [1:0] {
    IO_IDLE  = 2'b00,
    IO_LOAD  = 2'b01,
    IO_STORE = 2'b10
  } fos_io_t;
  typedef enum logic {
    E_IDLE = 1'b0,
    E_RUN  = 1'b1
  } fos_eng_t;
  // Reverse the low n bits of v, keep the upper bits
  function automatic logic [6:0] fos_blk_rev(input logic [6:0] v, input logic [2:0] n);
    logic [6:0] r;
    r = v;
    for (int b = 0; b < 7; b++) begin
      if (b < int'(n)) r[b] = v[int'(n) - 1 - b];
    end
    return r;
  endfunction
endpackage

// ---- rtl/fos_ram_if.sv ----
// Purpose: Two-port butterfly access to the internal RAM
// Assumes: Reads are combinational
// Notes: One write strobe covers both ports
`timescale 1ns/1ps
interface fos_ram_if #(parameter int DW = 16);
  logic [6:0]      addr_a;
  logic [6:0]      addr_b;
  logic            we;
  logic [2*DW-1:0] wdata_a;
  logic [2*DW-1:0] wdata_b;
  logic [2*DW-1:0] rdata_a;
  logic [2*DW-1:0] rdata_b;
  modport eng (output addr_a, addr_b, we, wdata_a, wdata_b, input rdata_a, rdata_b);
  modport ram (input addr_a, addr_b, we, wdata_a, wdata_b, output rdata_a, rdata_b);
endinterface // fos_ram_if

// ---- rtl/fos_io_addr.sv ----
// Purpose: Internal RAM address of an I/O transfer
// Assumes: Block size given as log2
// Notes: Reversal stays within each block
`timescale 1ns/1ps
module fos_io_addr (
  input  wire logic [6:0] idx,
  input  wire logic       rev,
  input  wire logic [2:0] sub_log2,
  input  wire logic [6:0] base,
  output logic      [6:0] addr
);
  // ==========================================================
  // Address
  assign addr = base + (rev ? fos_pkg::fos_blk_rev(idx, sub_log2) : idx);
endmodule // fos_io_addr

// ---- rtl/fos_xform_engine.sv ----
// Purpose: In-place radix-2 decimation-in-frequency passes
// Assumes: Coefficient ROM answers combinationally, index in 128-point units
// Notes: One butterfly per cycle, each output halved per pass
`timescale 1ns/1ps
module fos_xform_engine #(
  parameter int DW = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic [7:0]           length,
  input  wire logic [2:0]           sub_log2,
  input  wire logic [2:0]           fpg_log2,
  input  wire logic [2:0]           lpg_log2,
  input  wire logic [7:0]           coef_base,
  input  wire logic [6:0]           sect_base,
  output logic      [7:0]           coef_addr,
  input  wire logic signed [DW-1:0] coef_re,
  input  wire logic signed [DW-1:0] coef_im,
  output logic                      busy,
  output logic                      done,
  fos_ram_if.eng                    ram
);
  fos_pkg::fos_eng_t   st_q;
  logic [2:0]          gap_q, lpg_q, sub_q;
  logic [5:0]          k_q, klast_q;
  logic [7:0]          cb_q;
  logic [6:0]          base_q, kx, mask, i_off, j_off;
  logic signed [DW:0]  ar, ai, br, bi, sr, si, dr, di;
  logic signed [2*DW+1:0] pr, pi;
  // ==========================================================
  // Butterfly addressing
  assign kx    = {1'b0, k_q};
  assign mask  = (7'h01 << gap_q) - 7'h01;
  assign i_off = ((kx >> gap_q) << (gap_q + 3'h1)) | (kx & mask);
  assign j_off = i_off | (7'h01 << gap_q);
  assign ram.addr_a = base_q + i_off;
  assign ram.addr_b = base_q + j_off;
  assign coef_addr  = cb_q + {1'b0, (kx & mask) << (3'h6 - gap_q)};
  // ==========================================================
  // Arithmetic
  assign ar = {ram.rdata_a[2*DW-1], ram.rdata_a[2*DW-1:DW]};
  assign ai = {ram.rdata_a[DW-1], ram.rdata_a[DW-1:0]};
  assign br = {ram.rdata_b[2*DW-1], ram.rdata_b[2*DW-1:DW]};
  assign bi = {ram.rdata_b[DW-1], ram.rdata_b[DW-1:0]};
  assign sr = ar + br;
  assign si = ai + bi;
  assign dr = ar - br;
  assign di = ai - bi;
  assign pr = dr * coef_re - di * coef_im;
  assign pi = dr * coef_im + di * coef_re;
  assign ram.wdata_a = {sr[DW:1], si[DW:1]};
  assign ram.wdata_b = {pr[2*DW-1:DW], pi[2*DW-1:DW]};
  assign ram.we = st_q == fos_pkg::E_RUN;
  assign busy   = st_q == fos_pkg::E_RUN;
  // ==========================================================
  // Pass sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= fos_pkg::E_IDLE;
      gap_q   <= '0;
      lpg_q   <= '0;
      sub_q   <= '0;
      k_q     <= '0;
      klast_q <= '0;
      cb_q    <= '0;
      base_q  <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        fos_pkg::E_IDLE: if (start && length > 8'h01) begin
          st_q    <= fos_pkg::E_RUN;
          // Gaps of one small transform or more are cut back to half its size
          gap_q   <= (fpg_log2 < sub_log2) ? fpg_log2 : sub_log2 - 3'h1;
          lpg_q   <= lpg_log2;
          sub_q   <= sub_log2;
          k_q     <= '0;
          klast_q <= 6'((length >> 1) - 8'h01);
          cb_q    <= coef_base;
          base_q  <= sect_base;
        end
        fos_pkg::E_RUN: begin
          k_q <= k_q + 6'h01;
          if (k_q == klast_q) begin
            k_q <= '0;
            if (gap_q <= lpg_q) begin
              st_q <= fos_pkg::E_IDLE;
              done <= 1'b1;
            end else begin
              gap_q <= gap_q - 3'h1;
            end
          end
        end
        default: st_q <= fos_pkg::E_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Checks
  property p_gap_down;
    @(posedge clk) disable iff (rst)
    busy && k_q == klast_q && gap_q > lpg_q |=> busy && gap_q == $past(gap_q) - 3'h1 && k_q == 6'h00;
  endproperty
  a_gap_down: assert property (p_gap_down) else $error("pass gap did not halve");
  property p_pair_gap;
    @(posedge clk) disable iff (rst)
    ram.we |-> (ram.addr_b - ram.addr_a) == (7'h01 << gap_q);
  endproperty
  a_pair_gap: assert property (p_pair_gap) else $error("butterfly pair spacing wrong");
  property p_in_block;
    @(posedge clk) disable iff (rst)
    ram.we |-> (i_off >> sub_q) == (j_off >> sub_q);
  endproperty
  a_in_block: assert property (p_in_block) else $error("butterfly crosses small transform");
endmodule // fos_xform_engine

// ---- rtl/fos_sequencer.sv ----
// Purpose: Fetch, overlap issue and I/O transfers of the transform sequencer
// Assumes: Program and data memories run on clk; program memory reads combinationally
// Notes: External data answers a read in the cycle after the read strobe
`timescale 1ns/1ps
`include "fos_cfg.svh"
module fos_sequencer #(
  parameter int DW  = 16,
  parameter int PAW = 10
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  output logic      [PAW-1:0]       prog_addr,
  input  wire logic [31:0]          prog_data,
  output logic      [15:0]          ext_addr,
  output logic      [2*DW-1:0]      ext_wdata,
  input  wire logic [2*DW-1:0]      ext_rdata,
  output logic                      ext_re,
  output logic                      ext_we,
  output logic      [7:0]           coef_addr,
  input  wire logic signed [DW-1:0] coef_re,
  input  wire logic signed [DW-1:0] coef_im
);
  localparam int CW = 2 * DW;
  // ==========================================================
  // Declarations
  logic [PAW-1:0]      start_q;
  logic                run_q;
  logic [31:0]         rdata_q;
  fos_pkg::fos_fetch_t fst_q;
  logic [PAW-1:0]      paddr_q;
  logic [PAW-1:0]      jump_tgt;
  logic [31:0]         ins_q;
  logic                both_q;
  fos_pkg::fos_io_t    io_st_q;
  logic [7:0]          io_idx_q;
  logic [7:0]          io_len_q;
  logic [15:0]         io_ext_q;
  logic                io_half_q;
  logic                io_rev_q;
  logic [2:0]          io_sub_q;
  logic [1:0]          io_mask_q;
  logic [1:0]          alu_mask_q;
  logic [6:0]          io_base;
  logic [6:0]          io_ram_addr;
  logic [6:0]          ld_wa1_q;
  logic [6:0]          ld_wa2_q;
  logic                ld_wv_q;
  logic                ext_re_q;
  logic                ext_we_q;
  logic [15:0]         ext_addr_q;
  logic [CW-1:0]       ext_wdata_q;
  logic [CW-1:0]       ram_q [`FOS_RAM_WORDS];
  logic [3:0]          op;
  logic [7:0]          ins_len;
  logic [1:0]          ins_mask;
  logic [6:0]          ins_base;
  logic                is_io;
  logic                is_alu;
  logic                is_both;
  logic                is_jump;
  logic                is_load;
  logic                io_busy;
  logic                eng_busy;
  logic                eng_done;
  logic                eng_start;
  logic                io_go;
  logic                fire;
  logic                conflict_io;
  logic                conflict_alu;
  logic                can_issue;

  fos_ram_if #(.DW(DW)) ram_bus ();

  // RAM halves touched by a transfer of the given length
  function automatic logic [1:0] sect_mask(input logic half, input logic [7:0] len);
    if (len > `FOS_HALF_WORDS) sect_mask = 2'b11;
    else sect_mask = half ? 2'b10 : 2'b01;
  endfunction

  // ==========================================================
  // Instruction decode
  assign op       = ins_q[`FOS_OP_HI:`FOS_OP_LO];
  assign ins_len  = ins_q[`FOS_LEN_HI:`FOS_LEN_LO];
  assign is_io    = (op == `FOS_OP_BRING) || (op == `FOS_OP_WOUT);
  assign is_alu   = op == `FOS_OP_XFORM;
  assign is_both  = op[3:2] == `FOS_OP_BOTH;
  assign is_jump  = op == `FOS_OP_JUMP;
  assign is_load  = (op == `FOS_OP_BRING) || (is_both && !op[0]);
  assign ins_mask = sect_mask(ins_q[`FOS_F_HALF], ins_len);
  assign ins_base = (ins_mask == 2'b11) ? 7'h00 : {ins_q[`FOS_F_HALF], 6'h00};
  assign jump_tgt = prog_data[PAW-1:0];

  // ==========================================================
  // Overlap issue
  assign io_busy      = (io_st_q != fos_pkg::IO_IDLE) || ext_re_q || ld_wv_q;
  assign conflict_io  = (|(ins_mask & alu_mask_q)) && eng_busy;
  assign conflict_alu = (|(ins_mask & io_mask_q)) && io_busy;

  always_comb begin
    can_issue = 1'b1;
    if (is_io) begin
      can_issue = !io_busy && !both_q && !conflict_io;
    end else if (is_alu) begin
      can_issue = !eng_busy && !both_q && !conflict_alu;
    end else if (is_both) begin
      can_issue = !io_busy && !eng_busy;
    end
  end

  assign fire      = (fst_q == fos_pkg::F_ISSUE) && can_issue && !is_jump;
  assign io_go     = fire && (is_io || is_both);
  assign eng_start = fire && is_alu;

  // ==========================================================
  // Fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fst_q   <= fos_pkg::F_IDLE;
      paddr_q <= '0;
      ins_q   <= '0;
    end else if (reg_wr && reg_addr == `FOS_REG_CTRL && reg_wdata[`FOS_CTRL_RUN]) begin
      paddr_q <= start_q;
      fst_q   <= fos_pkg::F_FETCH;
    end else begin
      case (fst_q)
        fos_pkg::F_IDLE: if (run_q) begin
          fst_q <= fos_pkg::F_FETCH;
        end
        fos_pkg::F_FETCH: if (!run_q) begin
          fst_q <= fos_pkg::F_IDLE;
        end else begin
          ins_q   <= prog_data;
          paddr_q <= paddr_q + 1'b1;
          fst_q   <= fos_pkg::F_ISSUE;
        end
        fos_pkg::F_ISSUE: if (is_jump) begin
          paddr_q <= ins_q[PAW-1:0];
          fst_q   <= fos_pkg::F_JUMP;
        end else if (can_issue) begin
          fst_q <= fos_pkg::F_FETCH;
        end
        fos_pkg::F_JUMP: begin
          paddr_q <= jump_tgt;
          fst_q   <= fos_pkg::F_FETCH;
        end
        default: fst_q <= fos_pkg::F_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Unit reservations
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      both_q <= 1'b0;
    end else if (fire && is_both) begin
      both_q <= 1'b1;
    end else if (both_q && !io_busy) begin
      both_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alu_mask_q <= '0;
    end else if (eng_start) begin
      alu_mask_q <= ins_mask;
    end
  end

  // ==========================================================
  // I/O transfers
  assign io_base = (io_mask_q == 2'b11) ? 7'h00 : {io_half_q, 6'h00};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_st_q     <= fos_pkg::IO_IDLE;
      io_idx_q    <= '0;
      io_len_q    <= '0;
      io_ext_q    <= '0;
      io_half_q   <= 1'b0;
      io_rev_q    <= 1'b0;
      io_sub_q    <= '0;
      io_mask_q   <= '0;
      ext_re_q    <= 1'b0;
      ext_we_q    <= 1'b0;
      ext_addr_q  <= '0;
      ext_wdata_q <= '0;
      ld_wa1_q    <= '0;
    end else begin
      ext_re_q <= 1'b0;
      ext_we_q <= 1'b0;
      case (io_st_q)
        fos_pkg::IO_IDLE: if (io_go && ins_len != 8'h00) begin
          io_st_q   <= is_load ? fos_pkg::IO_LOAD : fos_pkg::IO_STORE;
          io_idx_q  <= '0;
          io_len_q  <= ins_len;
          io_ext_q  <= ins_q[`FOS_EXT_HI:`FOS_EXT_LO];
          io_half_q <= ins_q[`FOS_F_HALF];
          io_rev_q  <= ins_q[`FOS_F_REV];
          io_sub_q  <= ins_q[`FOS_SUB_HI:`FOS_SUB_LO];
          io_mask_q <= ins_mask;
        end
        fos_pkg::IO_LOAD, fos_pkg::IO_STORE: begin
          ext_addr_q <= io_ext_q;
          io_ext_q   <= io_ext_q + 16'h0001;
          io_idx_q   <= io_idx_q + 8'h01;
          if (io_st_q == fos_pkg::IO_LOAD) begin
            ext_re_q <= 1'b1;
            ld_wa1_q <= io_ram_addr;
          end else begin
            ext_we_q    <= 1'b1;
            ext_wdata_q <= ram_q[io_ram_addr];
          end
          if (io_idx_q == io_len_q - 8'h01) begin
            io_st_q <= fos_pkg::IO_IDLE;
          end
        end
        default: io_st_q <= fos_pkg::IO_IDLE;
      endcase
    end
  end

  // Read data come back one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_wv_q  <= 1'b0;
      ld_wa2_q <= '0;
    end else begin
      ld_wv_q  <= ext_re_q;
      ld_wa2_q <= ld_wa1_q;
    end
  end

  fos_io_addr u_io_addr (
    .idx      (io_idx_q[6:0]),
    .rev      (io_rev_q),
    .sub_log2 (io_sub_q),
    .base     (io_base),
    .addr     (io_ram_addr)
  );

  // ==========================================================
  // Internal RAM
  always_ff @(posedge clk) begin
    if (ram_bus.we) begin
      ram_q[ram_bus.addr_a] <= ram_bus.wdata_a;
      ram_q[ram_bus.addr_b] <= ram_bus.wdata_b;
    end
    if (ld_wv_q) begin
      ram_q[ld_wa2_q] <= ext_rdata;
    end
  end

  assign ram_bus.rdata_a = ram_q[ram_bus.addr_a];
  assign ram_bus.rdata_b = ram_q[ram_bus.addr_b];

  fos_xform_engine #(.DW(DW)) u_engine (
    .clk       (clk),
    .rst       (rst),
    .start     (eng_start),
    .length    (ins_len),
    .sub_log2  (ins_q[`FOS_SUB_HI:`FOS_SUB_LO]),
    .fpg_log2  (ins_q[`FOS_FPG_HI:`FOS_FPG_LO]),
    .lpg_log2  (ins_q[`FOS_LPG_HI:`FOS_LPG_LO]),
    .coef_base (ins_q[`FOS_COEF_HI:`FOS_COEF_LO]),
    .sect_base (ins_base),
    .coef_addr (coef_addr),
    .coef_re   (coef_re),
    .coef_im   (coef_im),
    .busy      (eng_busy),
    .done      (eng_done),
    .ram       (ram_bus.eng)
  );

  // ==========================================================
  // Register port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      start_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `FOS_REG_CTRL:  run_q   <= reg_wdata[`FOS_CTRL_RUN];
        `FOS_REG_START: start_q <= reg_wdata[PAW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `FOS_REG_CTRL:  rdata_q[`FOS_CTRL_RUN] <= run_q;
          `FOS_REG_START: rdata_q[PAW-1:0] <= start_q;
          `FOS_REG_STATUS: begin
            rdata_q[3:0] <= {fst_q != fos_pkg::F_IDLE, both_q, io_busy, eng_busy};
            rdata_q[`FOS_STAT_PC_LO +: PAW] <= paddr_q;
          end
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign prog_addr = paddr_q;
  assign ext_addr  = ext_addr_q;
  assign ext_wdata = ext_wdata_q;
  assign ext_re    = ext_re_q;
  assign ext_we    = ext_we_q;

  // ==========================================================
  // Checks
  property p_io_under_alu;
    @(posedge clk) disable iff (rst)
    fst_q == fos_pkg::F_ISSUE && is_io && eng_busy && !io_busy && !both_q && !conflict_io
      && ins_len != 8'h00 |=> io_st_q != fos_pkg::IO_IDLE;
  endproperty
  a_io_under_alu: assert property (p_io_under_alu) else $error("I/O held by running transform");
  property p_alu_hold;
    @(posedge clk) disable iff (rst)
    fst_q == fos_pkg::F_ISSUE && is_alu && eng_busy |-> !eng_start;
  endproperty
  a_alu_hold: assert property (p_alu_hold) else $error("transform issued over running one");
  property p_io_chain;
    @(posedge clk) disable iff (rst)
    $fell(io_busy) && fst_q == fos_pkg::F_ISSUE && is_io && !conflict_io && !both_q
      && ins_len != 8'h00 |=> io_busy ##1 (io_busy || ext_we_q);
  endproperty
  a_io_chain: assert property (p_io_chain) else $error("queued I/O not started");
  property p_no_clash;
    @(posedge clk) disable iff (rst)
    io_busy && eng_busy |-> (io_mask_q & alu_mask_q) == 2'b00;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("RAM half shared by I/O and transform");
  property p_both_alone;
    @(posedge clk) disable iff (rst)
    both_q |-> !eng_busy && !eng_start && !(fire && is_io);
  endproperty
  a_both_alone: assert property (p_both_alone) else $error("combined op overlapped");
  property p_jump;
    @(posedge clk) disable iff (rst)
    fst_q == fos_pkg::F_JUMP && !reg_wr |=> fst_q == fos_pkg::F_FETCH && paddr_q == $past(jump_tgt);
  endproperty
  a_jump: assert property (p_jump) else $error("indirect jump target wrong");
  property p_load_stream;
    @(posedge clk) disable iff (rst)
    ext_re_q && $past(ext_re_q) |-> ext_addr_q == $past(ext_addr_q) + 16'h0001 ##1 ld_wv_q;
  endproperty
  a_load_stream: assert property (p_load_stream) else $error("load addresses not consecutive");
  property p_rev_store;
    @(posedge clk) disable iff (rst)
    io_st_q == fos_pkg::IO_STORE && io_rev_q |->
      io_ram_addr == io_base + fos_pkg::fos_blk_rev(io_idx_q[6:0], io_sub_q);
  endproperty
  a_rev_store: assert property (p_rev_store) else $error("store not bit-reversed");
  property p_section;
    @(posedge clk) disable iff (rst)
    io_st_q != fos_pkg::IO_IDLE && sect_mask(io_half_q, io_len_q) != 2'b11 |->
      io_ram_addr[6] == io_half_q;
  endproperty
  a_section: assert property (p_section) else $error("I/O left its RAM half");
  property p_alu_release;
    @(posedge clk) disable iff (rst)
    eng_done |-> !eng_busy;
  endproperty
  a_alu_release: assert property (p_alu_release) else $error("engine busy after done");
endmodule // fos_sequencer

// ---- test/fos_ext_mem.sv ----
// Purpose: External data memory model facing the sequencer
// Assumes: Read data stands in the cycle after ext_re
// Notes: Outside a read the data bus shows a changing pattern
`timescale 1ns/1ps
module fos_ext_mem (
  input  wire logic        clk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [31:0] ext_wdata,
  input  wire logic        ext_re,
  input  wire logic        ext_we,
  output logic      [31:0] ext_rdata
);
  logic [31:0] mem [0:65535];
  initial ext_rdata = 32'h5a5a_a5a5;
  always @(posedge clk) begin
    if (ext_we) mem[ext_addr] <= ext_wdata;
    ext_rdata <= ext_re ? mem[ext_addr] : ~ext_rdata;
  end
endmodule // fos_ext_mem

// ---- test/test_fos_sequencer.sv ----
// Purpose: Self-checking bench of the transform sequencer
// Assumes: Program memory answers in the same cycle
// Notes: Each program ends in an indirect jump onto itself
`timescale 1ns/1ps
module test_fos_sequencer;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, ext_wdata, ext_rdata, v;
  logic [31:0] prog [0:1023];
  logic [9:0]  prog_addr;
  logic [15:0] ext_addr;
  logic [7:0]  coef_addr;
  logic        ext_re, ext_we;
  int          miscompares = 0, comparisons = 0, n;
  always #12.5 clk = ~clk;
  fos_sequencer u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
    .prog_data(prog[prog_addr]), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ext_re(ext_re), .ext_we(ext_we), .coef_addr(coef_addr),
    .coef_re(16'h7fff), .coef_im(16'h0000));
  fos_ext_mem u_mem (.clk(clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_re(ext_re), .ext_we(ext_we), .ext_rdata(ext_rdata));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Runs from start, waits for the halt jump, stops and lets I/O drain
  task automatic run_to_halt(input logic [9:0] start, input logic [9:0] halt);
    prog[10'h3ff] = {22'h0, halt};
    wr(4'h4, {22'h0, start});
    wr(4'h0, 32'h1);
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (prog_addr === 10'h3ff) break;
    end
    if (n == 3000) begin
      check("halt reached", 32'h1, 32'h0);
      give_verdict();
    end
    for (n = 0; n < 4 && prog_addr !== halt; n++) @(negedge clk);
    check("jump target", {22'h0, halt}, {22'h0, prog_addr});
    wr(4'h0, 32'h0);
    for (n = 0; n < 500; n++) begin
      rd(4'h8, v);
      if (v[1:0] === 2'b00) break;
    end
    if (n == 500) begin
      check("units idle", 32'h0, {30'h0, v[1:0]});
      give_verdict();
    end
  endtask
  task automatic test_rev_store;
    for (int i = 0; i < 4; i++) u_mem.mem[16'h8010 + i] = 32'h1000 + i;
    prog[0] = 32'h1008_8010; // Load 4 points, block size 4, half 0
    prog[1] = 32'h2408_8020; // Store 4 points reversed
    prog[2] = 32'h4000_03ff;
    run_to_halt(10'h000, 10'h002);
    check("out 0", 32'h1000, u_mem.mem[16'h8020]);
    check("out 1", 32'h1002, u_mem.mem[16'h8021]);
    check("out 2", 32'h1001, u_mem.mem[16'h8022]);
    check("out 3", 32'h1003, u_mem.mem[16'h8023]);
    rd(4'hc, v);
    check("unmapped read", 32'h0, v);
    $display("test_rev_store done");
  endtask
  task automatic test_overlap;
    prog[10] = 32'h3081_a800; // Transform 64 points on half 0, gaps 32 down to 1
    prog[11] = 32'h1808_8010; // Load on half 1
    prog[12] = 32'h4000_03ff;
    wr(4'h4, 32'h0000_000a);
    prog[10'h3ff] = 32'h0000_000c;
    wr(4'h0, 32'h1);
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (ext_re === 1'b1) break;
    end
    check("load start under transform", 32'h1, {31'h0, n < 40});
    run_to_halt(10'h00a, 10'h00c);
    $display("test_overlap done");
  endtask
  // Two 4-point transforms in one instruction, each block filled with its own constant
  task automatic test_groups;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) u_mem.mem[16'h8040 + i] = (i < 4) ? 32'h0100_0200 : 32'h0300_0400;
    prog[20] = 32'h8010_8040; // Combined-op load of 8 points, half 0
    prog[21] = 32'h3010_8800; // Size 4, gaps 2 down to 1 given for one block
    prog[22] = 32'h2410_8050; // Store 8 points reversed within 4-point blocks
    prog[23] = 32'h4000_03ff;
    run_to_halt(10'h014, 10'h017);
    for (int i = 0; i < 8; i++) begin
      e = (i == 0) ? 32'h0100_0200 : (i == 4) ? 32'h0300_0400 : 32'h0;
      check("group out", e, u_mem.mem[16'h8050 + i]);
    end
    $display("test_groups done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) prog[i] = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset strobes", 32'h0, {20'h0, ext_re, ext_we, prog_addr});
    check("reset data", 32'h0, reg_rdata | ext_wdata);
    check("reset addresses", 32'h0, {8'h0, ext_addr, coef_addr});
    test_rev_store();
    test_overlap();
    test_groups();
    give_verdict();
  end
endmodule // test_fos_sequencer
